//--- verilog/qsld_regs.svh
// Constants for the quad serial low-side driver control block
`ifndef QSLD_REGS_SVH
`define QSLD_REGS_SVH

// ==========================================================
// Channel layout
`define QSLD_CHANNELS          4
`define QSLD_HOLD_RESET        4'h0
`define QSLD_OUT_RESET         4'h0

// ==========================================================
// Timing, core clock at 200 MHz
`define QSLD_CLK_PERIOD_NS     5
`define QSLD_OCP_DEGLITCH_NS   3500
`define QSLD_OCP_RETRY_NS      1200000
`define QSLD_RESET_RECOVERY_NS 20000
`define QSLD_STARTUP_NS        55000
`define QSLD_OCP_DEGLITCH_CYC  ((`QSLD_OCP_DEGLITCH_NS + `QSLD_CLK_PERIOD_NS - 1) / `QSLD_CLK_PERIOD_NS)
`define QSLD_OCP_RETRY_CYC     (`QSLD_OCP_RETRY_NS / `QSLD_CLK_PERIOD_NS)
`define QSLD_POR_CYC           16

`endif

//--- verilog/qsld_pkg.sv
// Types shared by the quad serial low-side driver control block
package qsld_pkg;

    // ======================================================
    // Per-channel overcurrent protection states
    typedef enum logic [1:0] {
        OC_IDLE,
        OC_FILTER,
        OC_RETRY
    } ocState_e;

    typedef logic [3:0] chanMask_t;

endpackage : qsld_pkg

//--- verilog/shift_link_if.sv
// Carrier between the core logic and the shift-clock logic
`timescale 1ns/1ps
interface shift_link_if;
    import qsld_pkg::*;

    logic      clearLink;
    chanMask_t holdWord;

    modport link (input clearLink, output holdWord);
    modport core (output clearLink, input holdWord);

endinterface : shift_link_if

//--- verilog/serial_shift_link.sv
// Holding shift register clocked by the host's shift clock
`timescale 1ns/1ps
`include "qsld_regs.svh"
module serial_shift_link
    import qsld_pkg::*;
(
    input  wire logic   shiftClk,
    input  wire logic   serialIn,
    output logic        chainOut,
    shift_link_if.link  link
);

    // ======================================================
    // Holding register
    // The clear is asynchronous: the shift clock stands still between
    // frames, so a clocked clear could not act until the next frame.
    chanMask_t hold_reg;

    always_ff @(posedge shiftClk or posedge link.clearLink) begin
        if (link.clearLink) begin
            hold_reg <= `QSLD_HOLD_RESET;
        end else begin
            hold_reg <= {hold_reg[2:0], serialIn};
        end
    end

    assign link.holdWord = hold_reg;
    // Bit leaving the register feeds the next device in the chain
    assign chainOut      = hold_reg[3];

endmodule : serial_shift_link

//--- verilog/quad_serial_lowside_driver_ctrl.sv
// Core control of the four-channel protected low-side switch
`timescale 1ns/1ps
`include "qsld_regs.svh"

module quad_serial_lowside_driver_ctrl
    import qsld_pkg::*;
#(
    parameter int unsigned DeglitchCycles = `QSLD_OCP_DEGLITCH_CYC,
    parameter int unsigned RetryCycles    = `QSLD_OCP_RETRY_CYC,
    parameter int unsigned PorCycles      = `QSLD_POR_CYC
)(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       shiftClk,
    input  wire logic       serial_in,
    output logic            chain_out,
    input  wire logic       loadStrobe,
    input  wire logic       drivers_on_low,
    input  wire logic [3:0] overcurrent_trip,
    input  wire logic       thermal_trip,
    input  wire logic       low_supply_lockout,
    output logic [3:0]      switchOn,
    output logic            fault_flag_low_out,
    output logic            fault_flag_low_oe
);

    // ======================================================
    // Parameter checks
    localparam int unsigned CntWidth = $clog2(RetryCycles + DeglitchCycles + 2);

    if (DeglitchCycles < 1 || RetryCycles < 2 || PorCycles < 1) begin : bad_timing
        $error("quad_serial_lowside_driver_ctrl: timing counts out of range");
    end

    // ======================================================
    // Pin synchronisers
    logic [3:0] ocMeta_reg;
    logic [3:0] ocSync_reg;
    logic       tempMeta_reg;
    logic       tempSync_reg;
    logic       lowMeta_reg;
    logic       lowSync_reg;
    logic       enMeta_reg;
    logic       enSync_reg;
    logic       strobeMeta_reg;
    logic       strobeSync_reg;
    logic       strobeSeen_reg;

    always_ff @(posedge core_clk) begin
        ocMeta_reg     <= overcurrent_trip;
        ocSync_reg     <= ocMeta_reg;
        tempMeta_reg   <= thermal_trip;
        tempSync_reg   <= tempMeta_reg;
        lowMeta_reg    <= low_supply_lockout;
        lowSync_reg    <= lowMeta_reg;
        enMeta_reg     <= drivers_on_low;
        enSync_reg     <= enMeta_reg;
        strobeMeta_reg <= loadStrobe;
        strobeSync_reg <= strobeMeta_reg;
        strobeSeen_reg <= strobeSync_reg;
    end

    // ======================================================
    // Power-up and supply reset
    // The counter starts from its declared value so that no pin is
    // needed to bring the logic out of power-up.
    logic [$clog2(PorCycles + 1) - 1:0] porCount_reg = '0;
    logic                               porBusy_reg  = 1'b1;
    logic                               intRst;

    always_ff @(posedge core_clk) begin
        if (lowSync_reg) begin
            porCount_reg <= '0;
            porBusy_reg  <= 1'b1;
        end else if (porBusy_reg) begin
            if (porCount_reg == ($clog2(PorCycles + 1))'(PorCycles - 1)) begin
                porBusy_reg <= 1'b0;
            end
            porCount_reg <= porCount_reg + 1'b1;
        end
    end

    assign intRst = reset | porBusy_reg | lowSync_reg;

    // ======================================================
    // Link domain
    // Host keeps the shift clock still for the recovery delays after
    // reset and power-up, so the clear releases away from any edge.
    shift_link_if link ();

    logic clearLink_reg;

    always_ff @(posedge core_clk) begin
        clearLink_reg <= intRst;
    end

    assign link.clearLink = clearLink_reg;

    serial_shift_link u_link (
        .shiftClk (shiftClk),
        .serialIn (serial_in),
        .chainOut (chain_out),
        .link     (link.link)
    );

    // ======================================================
    // Holding word crossing
    // The word is quiet while the strobe rises, and the strobe rise is taken
    // after the same two stages as the word, so the copy is settled.
    chanMask_t holdMeta_reg;
    chanMask_t holdSync_reg;

    always_ff @(posedge core_clk) begin
        holdMeta_reg <= link.holdWord;
        holdSync_reg <= holdMeta_reg;
    end

    // ======================================================
    // Output stage
    chanMask_t outStage_reg;
    logic      strobeRise;

    assign strobeRise = strobeSync_reg & ~strobeSeen_reg;

    // Strobe transfer ignores the enable level
    always_ff @(posedge core_clk) begin
        if (intRst) begin
            outStage_reg <= `QSLD_OUT_RESET;
        end else if (strobeRise) begin
            outStage_reg <= holdSync_reg;
        end
    end

    // ======================================================
    // Overcurrent protection per channel
    ocState_e              ocState_reg [4];
    logic [CntWidth - 1:0] ocCount_reg [4];
    chanMask_t             ocOff;

    for (genvar ch = 0; ch < `QSLD_CHANNELS; ch++) begin : g_ocp
        always_ff @(posedge core_clk) begin
            if (intRst) begin
                ocState_reg[ch] <= OC_IDLE;
                ocCount_reg[ch] <= '0;
            end else begin
                case (ocState_reg[ch])
                    OC_IDLE: begin
                        ocCount_reg[ch] <= '0;
                        if (ocSync_reg[ch]) begin
                            ocState_reg[ch] <= OC_FILTER;
                        end
                    end
                    OC_FILTER: begin
                        if (!ocSync_reg[ch]) begin
                            ocState_reg[ch] <= OC_IDLE;
                            ocCount_reg[ch] <= '0;
                        end else if (ocCount_reg[ch] == CntWidth'(DeglitchCycles)) begin
                            ocState_reg[ch] <= OC_RETRY;
                            ocCount_reg[ch] <= '0;
                        end else begin
                            ocCount_reg[ch] <= ocCount_reg[ch] + 1'b1;
                        end
                    end
                    OC_RETRY: begin
                        if (ocCount_reg[ch] == CntWidth'(RetryCycles - 1)) begin
                            ocState_reg[ch] <= OC_IDLE;
                            ocCount_reg[ch] <= '0;
                        end else begin
                            ocCount_reg[ch] <= ocCount_reg[ch] + 1'b1;
                        end
                    end
                    default: begin
                        ocState_reg[ch] <= OC_IDLE;
                        ocCount_reg[ch] <= '0;
                    end
                endcase
            end
        end

        assign ocOff[ch] = (ocState_reg[ch] == OC_RETRY);
    end

    // ======================================================
    // Driver outputs and fault flag
    // Thermal shutdown is level driven: it needs no latch and no timer
    // to recover, unlike the overcurrent retry, which holds off for RetryCycles.
    chanMask_t switchOn_next;
    logic      fault_next;

    always_comb begin
        switchOn_next = outStage_reg & ~ocOff;
        if (intRst || enSync_reg || tempSync_reg) begin
            switchOn_next = '0;
        end
        fault_next = !intRst && (tempSync_reg || (|ocOff));
    end

    always_ff @(posedge core_clk) begin
        switchOn <= switchOn_next;
    end

    // Open drain: the pad only ever pulls low
    always_ff @(posedge core_clk) begin
        fault_flag_low_out <= 1'b0;
        fault_flag_low_oe  <= fault_next;
    end

endmodule : quad_serial_lowside_driver_ctrl

//--- verif/qsld_properties.sv
// Port-level checks of the low-side driver control block
`timescale 1ns/1ps
module qsld_properties
    import qsld_pkg::*;
#(
    parameter int unsigned DeglitchCycles = 20,
    parameter int unsigned RetryCycles    = 50
)(
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       shiftClk,
    input wire logic       serial_in,
    input wire logic       chain_out,
    input wire logic       loadStrobe,
    input wire logic       drivers_on_low,
    input wire logic [3:0] overcurrent_trip,
    input wire logic       thermal_trip,
    input wire logic       low_supply_lockout,
    input wire logic [3:0] switchOn,
    input wire logic       fault_flag_low_out,
    input wire logic       fault_flag_low_oe
);
    localparam int RetryBack = RetryCycles - 2;
    chanMask_t shadowReg;
    wire       clearShadow = reset | low_supply_lockout;
    wire       ocAny       = |overcurrent_trip;
    // Mirror of the holding register, so the link is judged without its internals
    always_ff @(posedge shiftClk or posedge clearShadow)
        shadowReg <= clearShadow ? 4'h0 : {shadowReg[2:0], serial_in};

    a_pad_low: assert property (@(posedge core_clk) disable iff (reset)
        !fault_flag_low_out) else $error("fault pad value not low");
    a_chain_order: assert property (@(posedge shiftClk) disable iff (reset)
        chain_out == shadowReg[3]) else $error("chain output out of order");
    a_strobe_load: assert property (@(posedge core_clk) disable iff (reset)
        $rose(loadStrobe) && !drivers_on_low && !thermal_trip && !ocAny |-> ##6 switchOn == shadowReg)
        else $error("strobe did not load the word");
    a_enable_gate: assert property (@(posedge core_clk) disable iff (reset)
        drivers_on_low[*5] |-> switchOn == 4'h0) else $error("switch on while disabled");
    a_reset_clear: assert property (@(posedge core_clk)
        reset |=> switchOn == 4'h0 && !fault_flag_low_oe) else $error("reset did not clear");
    a_ocp_deglitch: assert property (@(posedge core_clk) disable iff (reset)
        $rose(fault_flag_low_oe) && !thermal_trip |-> $past(ocAny, DeglitchCycles))
        else $error("overcurrent fault before deglitch time");
    a_ocp_retry: assert property (@(posedge core_clk) disable iff (reset)
        $fell(fault_flag_low_oe) && $past(ocAny, 3) |-> $past(fault_flag_low_oe, RetryBack))
        else $error("overcurrent fault released early");
    a_thermal_off: assert property (@(posedge core_clk) disable iff (reset)
        thermal_trip[*5] |-> switchOn == 4'h0 && fault_flag_low_oe) else $error("thermal trip ignored");
endmodule : qsld_properties

bind quad_serial_lowside_driver_ctrl qsld_properties #(
    .DeglitchCycles(DeglitchCycles), .RetryCycles(RetryCycles)) chk_u (
    .core_clk(core_clk), .reset(reset), .shiftClk(shiftClk), .serial_in(serial_in), .chain_out(chain_out),
    .loadStrobe(loadStrobe), .drivers_on_low(drivers_on_low), .overcurrent_trip(overcurrent_trip),
    .thermal_trip(thermal_trip), .low_supply_lockout(low_supply_lockout), .switchOn(switchOn),
    .fault_flag_low_out(fault_flag_low_out), .fault_flag_low_oe(fault_flag_low_oe));

//--- verif/host_shift_model.sv
// Host side of the serial link: shift clock, data and load strobe
`timescale 1ns/1ps
module host_shift_model (
    output logic shiftClk,
    output logic serialOut,
    output logic strobe
);
    initial begin
        shiftClk = 1'b0;
        serialOut = 1'b0;
        strobe = 1'b0;
    end
    // Clock runs only inside a frame; data moves on the falling edge for hold margin
    task automatic send_frame(input logic [3:0] word);
        for (int i = 3; i >= 0; i--) begin
            serialOut = word[i];
            #40;
            shiftClk = 1'b1;
            #40;
            shiftClk = 1'b0;
        end
        serialOut = 1'b0;
        #50;
        strobe = 1'b1;
        #250;
        strobe = 1'b0;
        #50;
    endtask : send_frame
endmodule : host_shift_model

//--- verif/quad_serial_lowside_driver_ctrl_bench.sv
// Self-checking bench of the low-side driver control block
`timescale 1ns/1ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin failCount++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module quad_serial_lowside_driver_ctrl_bench;
    import qsld_pkg::*;
    typedef struct packed {chanMask_t word; logic enLow; chanMask_t expOn;} row_s;
    logic      core_clk, reset, shiftClk, serialIn, loadStrobe, chainOut, faultOut, faultOe;
    logic      drivers_on_low, thermal_trip, low_supply_lockout;
    chanMask_t overcurrent_trip, switchOn;
    int        failCount = 0;
    int        samplesChecked = 0;
    int        waitCount;
    row_s      rows [4] = '{'{4'hA, 1'b0, 4'hA}, '{4'h5, 1'b0, 4'h5}, '{4'h1, 1'b0, 4'h1}, '{4'hF, 1'b1, 4'h0}};
    wire       faultLine = faultOe ? faultOut : 1'b1;

    host_shift_model host_u (.shiftClk(shiftClk), .serialOut(serialIn), .strobe(loadStrobe));
    quad_serial_lowside_driver_ctrl #(.DeglitchCycles(20), .RetryCycles(50), .PorCycles(4)) dut_u (
        .core_clk(core_clk), .reset(reset), .shiftClk(shiftClk), .serial_in(serialIn), .chain_out(chainOut),
        .loadStrobe(loadStrobe), .drivers_on_low(drivers_on_low), .overcurrent_trip(overcurrent_trip),
        .thermal_trip(thermal_trip), .low_supply_lockout(low_supply_lockout), .switchOn(switchOn),
        .fault_flag_low_out(faultOut), .fault_flag_low_oe(faultOe));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic wait_fault(input logic level);
        for (waitCount = 0; faultOe !== level && waitCount < 100; waitCount++) step(1);
    endtask : wait_fault
    task automatic final_report;
        if (failCount == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    // Run needs under 10 us; ten times that means a hang
    initial begin
        #100000;
        failCount++;
        final_report();
    end
    initial begin
        {reset, drivers_on_low, thermal_trip, low_supply_lockout} = 4'h8;
        overcurrent_trip = 4'h0;
        step(8);
        reset = 1'b0;
        step(12);
        foreach (rows[i]) begin
            drivers_on_low = rows[i].enLow;
            host_u.send_frame(rows[i].word);
            step(8);
            `CHK(chainOut, rows[i].word[3])
            `CHK(switchOn, rows[i].expOn)
        end
        drivers_on_low = 1'b0;
        step(6);
        `CHK(switchOn, 4'hF)
        overcurrent_trip = 4'h2;
        wait_fault(1'b1);
        `CHK(waitCount > 20, 1'b1)
        `CHK({faultLine, switchOn}, 5'h0D)
        wait_fault(1'b0);
        overcurrent_trip = 4'h0;
        `CHK(waitCount >= 48 && faultLine, 1'b1)
        overcurrent_trip = 4'h1;
        wait_fault(1'b1);
        overcurrent_trip = 4'h0;
        reset = 1'b1;
        step(2);
        `CHK({faultOe, switchOn}, 5'h00)
        step(6);
        `CHK(chainOut, 1'b0)
        reset = 1'b0;
        step(12);
        host_u.send_frame(4'h6);
        step(8);
        thermal_trip = 1'b1;
        step(5);
        `CHK({switchOn, faultOe}, 5'h01)
        thermal_trip = 1'b0;
        step(5);
        `CHK({switchOn, faultOe}, 5'h0C)
        low_supply_lockout = 1'b1;
        step(5);
        `CHK(switchOn, 4'h0)
        low_supply_lockout = 1'b0;
        step(12);
        `CHK({switchOn, chainOut}, 5'h00)
        host_u.send_frame(4'h9);
        step(8);
        `CHK(switchOn, 4'h9)
        final_report();
    end
endmodule : quad_serial_lowside_driver_ctrl_bench
